/* hdl/bit_ops_pkg.sv */
// Constants for the table bit-clear, carry and priority-encode execution block.
// Assumes one 10 MHz clock; no bus, all controls are plain ports.
package bit_ops_pkg;
   localparam int TABLE_WORDS_MAX = 64;
   localparam int TABLE_WORDS_MIN = 1;
   localparam int WORD_BITS = 16;
   localparam int WORD_SHIFT = 4;
   localparam int TABLE_BITS_MAX = 1024;
   localparam int PTR_WIDTH = 16;
   localparam int SIZE_WIDTH = 7;
   localparam int ENC_EXP_MIN = 1;
   localparam int ENC_EXP_MAX = 8;
   localparam int ENC_BITS_MAX = 256;
   localparam int ENC_POS_WIDTH = 8;
   localparam int EXP_WIDTH = 4;
   localparam logic CARRY_RESET = 1'b0;
   localparam logic ERROR_RESET = 1'b0;
endpackage : bit_ops_pkg

/* hdl/bit_table_mem.sv */
// Bit table storage: words of 16 bits, one word read per cycle, one bit cleared per write.
// Assumes the caller checks the word index against the table size.
`timescale 1ns/1ps
`default_nettype none
module bit_table_mem
   import bit_ops_pkg::*;
#(
   parameter int WORDS = TABLE_WORDS_MAX
) (
   input wire logic clock, // System clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic load_en, // Load one word from outside
   input wire logic [5:0] load_addr, // Word to load
   input wire logic [WORD_BITS-1:0] load_data, // Word value
   input wire logic clr_en, // Clear one bit
   input wire logic [5:0] clr_word, // Word holding the bit
   input wire logic [3:0] clr_bit, // Bit within the word
   input wire logic [5:0] rd_addr, // Read word address
   output logic [WORD_BITS-1:0] rd_data // Registered read data
);
   // The word index is six bits wide, so deeper tables cannot be served
   if (WORDS < TABLE_WORDS_MIN || WORDS > TABLE_WORDS_MAX) begin : g_words_bad
      $error("WORDS out of range");
   end

   logic [WORD_BITS-1:0] mem_q [WORDS];

   // Clear takes priority so a clear is never lost behind a load
   always_ff @(posedge clock) begin
      if (clr_en) begin
         mem_q[clr_word] <= mem_q[clr_word] & ~(16'h0001 << clr_bit);
      end else if (load_en) begin
         mem_q[load_addr] <= load_data;
      end
   end

   // Read data registered; reset gives a defined output
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_data <= 16'h0000;
      end else begin
         rd_data <= mem_q[rd_addr];
      end
   end
endmodule : bit_table_mem
`default_nettype wire

/* hdl/bit_table_carry_encode_ops.sv */
// Execution logic for table bit-clear, carry force and priority encode instructions.
// Assumes operands are stable while the matching strobe is high; single 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module bit_table_carry_encode_ops
   import bit_ops_pkg::*;
#(
   parameter int WORDS = TABLE_WORDS_MAX
) (
   input wire logic clock, // System clock, 10 MHz
   input wire logic rst_n, // Synchronous reset, active low
   // Table loading and inspection
   input wire logic load_en, // Write one table word
   input wire logic [5:0] load_addr, // Table word index
   input wire logic [WORD_BITS-1:0] load_data, // Table word value
   input wire logic [5:0] rd_addr, // Table word to read back
   output logic [WORD_BITS-1:0] rd_data, // Table word, one cycle after rd_addr
   // Table bit-clear
   input wire logic clear_exec, // Strobe: scan this rung
   input wire logic clear_rung_in, // Rung input condition
   input wire logic [PTR_WIDTH-1:0] clear_ptr, // Bit pointer
   input wire logic [SIZE_WIDTH-1:0] clear_size, // Table size in words
   output logic clear_rung_out, // Rung output
   // Carry operations
   input wire logic carry_force_one_op, // Strobe: set-carry instruction
   input wire logic carry_force_zero_op, // Strobe: clear-carry instruction
   input wire logic carry_rung_in, // Rung input condition
   output logic carry_rung_out, // Rung output
   output logic carry_flag, // Carry flag
   // Priority encoder
   input wire logic priority_encode_op, // Strobe: encode instruction
   input wire logic enc_rung_in, // Rung input condition
   input wire logic [ENC_BITS_MAX-1:0] enc_src, // Bit series, bit 0 is position 0
   input wire logic [EXP_WIDTH-1:0] enc_exp, // Size exponent n
   output logic [ENC_POS_WIDTH-1:0] enc_dest, // Stored position
   output logic enc_store, // Pulse: enc_dest was written
   output logic enc_rung_out, // Rung output
   // Shared
   input wire logic error_clear, // Pulse: clear the error flag
   output logic error_flag // Sticky error flag
);
   // Elaboration checks: the word index is six bits wide and the encoder window at most 256 bits,
   // so depths or constants beyond those cannot be served by the logic below
   if (WORDS < TABLE_WORDS_MIN || WORDS > TABLE_WORDS_MAX) begin : g_words_bad
      $error("WORDS out of range");
   end
   if (WORD_BITS != (1 << WORD_SHIFT)) begin : g_word_bad
      $error("WORD_BITS and WORD_SHIFT disagree");
   end
   if (ENC_BITS_MAX != (1 << ENC_EXP_MAX)) begin : g_enc_bad
      $error("ENC_BITS_MAX and ENC_EXP_MAX disagree");
   end
   if (TABLE_BITS_MAX != TABLE_WORDS_MAX * WORD_BITS) begin : g_bits_bad
      $error("TABLE_BITS_MAX does not match the table shape");
   end
   if ((1 << ENC_POS_WIDTH) != ENC_BITS_MAX) begin : g_pos_bad
      $error("ENC_POS_WIDTH does not cover the encoder window");
   end
   if ((1 << EXP_WIDTH) <= ENC_EXP_MAX) begin : g_exp_bad
      $error("EXP_WIDTH too narrow for the largest exponent");
   end
   if ((1 << SIZE_WIDTH) <= TABLE_WORDS_MAX) begin : g_size_bad
      $error("SIZE_WIDTH too narrow for the largest table");
   end
   if ((1 << PTR_WIDTH) < TABLE_BITS_MAX) begin : g_ptr_bad
      $error("PTR_WIDTH too narrow for the largest table");
   end

   // Pointer decode: word is pointer/16, bit is pointer mod 16
   wire [PTR_WIDTH-WORD_SHIFT-1:0] ptr_word = clear_ptr[PTR_WIDTH-1:WORD_SHIFT];
   wire [3:0] ptr_bit = clear_ptr[WORD_SHIFT-1:0];
   // Size is checked against what the memory holds; out-of-range sizes refuse the clear
   // A pointer of 512 words or more can never lie inside a 64-word table; testing the top bits
   // apart keeps the size compare narrow
   wire ptr_high = (ptr_word[11:9] != 3'h0);
   wire [9:0] size_wide = {3'h0, clear_size};
   wire size_ok = (clear_size >= 7'(TABLE_WORDS_MIN)) && (clear_size <= 7'(WORDS));
   wire ptr_in = size_ok && (size_wide > {1'b0, ptr_word[8:0]}) && !ptr_high;
   // The rung input gates both outcomes, so an OFF rung neither clears nor flags an error
   wire clear_scan = clear_exec && clear_rung_in;
   wire clear_do = clear_scan && ptr_in;
   wire clear_err = clear_scan && !ptr_in;

   // Carry decode: either strobe scans the rung; with both strobes on, the set is taken
   wire carry_strobe = carry_force_one_op || carry_force_zero_op;
   wire carry_set = carry_force_one_op && carry_rung_in;
   wire carry_zero = carry_force_zero_op && carry_rung_in && !carry_force_one_op;

   // Table storage; a clear lands at the edge that samples the strobe, and a read of the same
   // word at that edge still returns the old value, so the cleared bit shows one read later
   bit_table_mem #(
      .WORDS(WORDS)
   ) u_mem (
      .clock(clock),
      .rst_n(rst_n),
      .load_en(load_en),
      .load_addr(load_addr),
      .load_data(load_data),
      .clr_en(clear_do),
      .clr_word(ptr_word[5:0]),
      .clr_bit(ptr_bit),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // Priority encoder: mask to 2^n bits then keep the highest hit
   wire exp_ok = (enc_exp >= 4'(ENC_EXP_MIN)) && (enc_exp <= 4'(ENC_EXP_MAX));
   wire [ENC_BITS_MAX-1:0] enc_mask;
   logic [ENC_POS_WIDTH-1:0] enc_pos;
   logic enc_any;
   // Window of 2^n positions; an exponent outside 1..8 leaves it empty, which then reads as an error
   for (genvar g = 0; g < ENC_BITS_MAX; g++) begin : g_window
      assign enc_mask[g] = exp_ok && (g < (1 << enc_exp));
   end
   // Only bits inside the window take part in the search
   wire [ENC_BITS_MAX-1:0] enc_hits = enc_src & enc_mask;
   // A plain loop keeps the search readable; it costs a long priority chain,
   // which a 10 MHz clock tolerates easily
   always_comb begin
      enc_pos = 8'h00;
      enc_any = 1'b0;
      // Ascending scan so the last hit is the highest; bit 0 is position 0
      for (int i = 0; i < ENC_BITS_MAX; i++) begin
         if (enc_hits[i]) begin
            enc_pos = 8'(i);
            enc_any = 1'b1;
         end
      end
   end
   // Encode outcome: an OFF rung is neither a success nor an error
   wire enc_act = priority_encode_op && enc_rung_in;
   wire enc_ok = enc_act && enc_any;
   wire enc_err = enc_act && !enc_any;

   // Rung outputs: each is held until its instruction is scanned again, so a rung that is not
   // scanned in a cycle keeps showing the result of its last scan
   // Bit-clear output: on only for a clear that was carried out;
   // an OFF rung or a pointer beyond the table turns it off
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         clear_rung_out <= 1'b0;
      end else if (clear_exec) begin
         clear_rung_out <= clear_do;
      end
   end

   // Carry output follows the rung input on either carry strobe;
   // the flag itself is handled apart below
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         carry_rung_out <= 1'b0;
      end else if (carry_strobe) begin
         carry_rung_out <= carry_rung_in;
      end
   end

   // Encoder output: on only for a stored result;
   // an empty window or an OFF rung turns it off
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         enc_rung_out <= 1'b0;
      end else if (priority_encode_op) begin
         enc_rung_out <= enc_ok;
      end
   end

   // Carry flag; set wins if both strobes arrive together
   // With the rung OFF no branch is taken, so the flag simply holds
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         carry_flag <= CARRY_RESET;
      end else if (carry_set) begin
         carry_flag <= 1'b1;
      end else if (carry_zero) begin
         carry_flag <= 1'b0;
      end
   end

   // Store pulse: one cycle for each successful encode
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         enc_store <= 1'b0;
      end else begin
         enc_store <= enc_ok;
      end
   end

   // Destination untouched on error or input off,
   // so a failed encode never corrupts the last result
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         enc_dest <= 8'h00;
      end else if (enc_ok) begin
         enc_dest <= enc_pos;
      end
   end

   // Either instruction may raise the error; one flag serves the whole program
   wire error_set = clear_err || enc_err;
   // Error flag is sticky; a new error in the clear cycle wins over the clear, so none is lost
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         error_flag <= ERROR_RESET;
      end else if (error_set) begin
         error_flag <= 1'b1;
      end else if (error_clear) begin
         error_flag <= 1'b0;
      end
   end
endmodule : bit_table_carry_encode_ops
`default_nettype wire

/* testbench/bit_ops_monitor.sv */
// Port-level assertions for the bit-clear, carry and encode block.
// Bound onto the top module by the bench; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bit_ops_monitor
   import bit_ops_pkg::*;
#(
   parameter int WORDS = TABLE_WORDS_MAX
) (
   input wire logic clock, // System clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic clear_exec, // Bit-clear strobe
   input wire logic clear_rung_in, // Bit-clear rung input
   input wire logic clear_rung_out, // Bit-clear rung output
   input wire logic carry_force_one_op, // Carry set strobe
   input wire logic carry_force_zero_op, // Carry clear strobe
   input wire logic carry_rung_in, // Carry rung input
   input wire logic carry_rung_out, // Carry rung output
   input wire logic carry_flag, // Carry flag
   input wire logic priority_encode_op, // Encode strobe
   input wire logic enc_rung_in, // Encode rung input
   input wire logic enc_store, // Encode store pulse
   input wire logic enc_rung_out, // Encode rung output
   input wire logic error_flag, // Sticky error flag
   input wire logic [PTR_WIDTH-1:0] clear_ptr, // Bit pointer
   input wire logic [SIZE_WIDTH-1:0] clear_size, // Table size in words
   input wire logic [ENC_BITS_MAX-1:0] enc_src, // Encoder bit series
   input wire logic [EXP_WIDTH-1:0] enc_exp // Encoder exponent
);
   // Window of 2^n bits; an exponent outside 1..8 leaves it empty so it counts as an error
   wire logic [255:0] enc_mask = (enc_exp inside {[1:8]}) ? (256'h1 << (1 << enc_exp)) - 256'h1 : '0;
   wire logic enc_hit = |(enc_src & enc_mask);
   wire logic clr_ok = clear_size != 7'h0 && clear_size <= WORDS && clear_ptr[15:4] < clear_size;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_carry_set: assert property (carry_force_one_op && carry_rung_in |=> carry_flag && carry_rung_out)
      else $error("carry set failed");
   a_carry_zero: assert property (carry_force_zero_op && !carry_force_one_op && carry_rung_in |=>
      !carry_flag && carry_rung_out) else $error("carry clear failed");
   a_carry_hold: assert property ((carry_force_one_op || carry_force_zero_op) && !carry_rung_in |=>
      !carry_rung_out && carry_flag == $past(carry_flag)) else $error("carry not held");
   a_enc_good: assert property (priority_encode_op && enc_rung_in && enc_hit |=> enc_store && enc_rung_out)
      else $error("encode store missing");
   a_enc_empty: assert property (priority_encode_op && enc_rung_in && !enc_hit |=>
      error_flag && !enc_store && !enc_rung_out) else $error("encode error missing");
   a_store_cause: assert property (enc_store |-> $past(priority_encode_op) && $past(enc_rung_in))
      else $error("store without encode");
   a_clear_bad: assert property (clear_exec && clear_rung_in && !clr_ok |=> error_flag && !clear_rung_out)
      else $error("range error missing");
   a_clear_good: assert property (clear_exec && clear_rung_in && clr_ok |=> clear_rung_out)
      else $error("clear output off");
endmodule : bit_ops_monitor
`default_nettype wire

/* testbench/bit_table_carry_encode_ops_test.sv */
// Self-checking bench: loads the table, then clears bits, encodes and forces carry.
// Drives at the falling edge; a watcher compares outputs just after the rising edge that follows each step.
`timescale 1ns/1ps
`default_nettype none
module bit_table_carry_encode_ops_test;
   import bit_ops_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, chk = 1'b0, load_en, clear_exec, clear_rung_in, carry_force_one_op;
   logic carry_force_zero_op, carry_rung_in, priority_encode_op, enc_rung_in, error_clear;
   logic clear_rung_out, carry_rung_out, carry_flag, enc_store, enc_rung_out, error_flag;
   logic [5:0] load_addr, rd_addr;
   logic [15:0] load_data, clear_ptr, rd_data;
   logic [6:0] clear_size;
   logic [255:0] enc_src;
   logic [3:0] enc_exp;
   logic [7:0] enc_dest, ed = 8'h0;
   logic [15:0] mem [64];
   int ptr_list [8] = '{56, 79, 80, 96, 1023, 0, 64, 3};
   int size_list [8] = '{5, 5, 5, 5, 64, 0, 65, 5};
   logic cf = 1'b0, ef = 1'b0, cro = 1'b0, kro = 1'b0, ero = 1'b0, est = 1'b0;
   logic [29:0] notes [$];
   int failures = 0, compares = 0;
   wire logic [29:0] seen = {clear_rung_out, carry_rung_out, carry_flag, enc_store, enc_rung_out, enc_dest,
      error_flag, rd_data};
   bit_table_carry_encode_ops i_dut (
      .clock(clock),
      .rst_n(rst_n),
      .load_en(load_en),
      .load_addr(load_addr),
      .load_data(load_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .clear_exec(clear_exec),
      .clear_rung_in(clear_rung_in),
      .clear_ptr(clear_ptr),
      .clear_size(clear_size),
      .clear_rung_out(clear_rung_out),
      .carry_force_one_op(carry_force_one_op),
      .carry_force_zero_op(carry_force_zero_op),
      .carry_rung_in(carry_rung_in),
      .carry_rung_out(carry_rung_out),
      .carry_flag(carry_flag),
      .priority_encode_op(priority_encode_op),
      .enc_rung_in(enc_rung_in),
      .enc_src(enc_src),
      .enc_exp(enc_exp),
      .enc_dest(enc_dest),
      .enc_store(enc_store),
      .enc_rung_out(enc_rung_out),
      .error_clear(error_clear),
      .error_flag(error_flag)
   );
   // 10 MHz clock
   initial forever #50 clock = ~clock;
   task automatic end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic check(input logic [29:0] got, input logic [29:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] outputs expected %h seen %h", exp, got);
      end
   endtask : check
   // Watcher: the oldest note belongs to the step taken at this edge
   always @(posedge clock) if (chk) begin
      #1;
      if (notes.size() == 0) begin
         failures++;
         $display("[FAIL] outputs expected a note seen none");
      end else begin
         check(seen, notes.pop_front());
      end
   end
   // One step: 0 idle, 1 clear, 2/3 carry one/zero, 4 encode, 5 error clear, 6 load (unchecked),
   // 7 both carry strobes at once, 8 encode with an error clear in the same cycle
   task automatic step(input int k, input logic ri, input logic [255:0] src, input logic [3:0] ex,
      input logic [15:0] p, input logic [6:0] sz);
      logic [255:0] m;
      logic [15:0] rd;
      @(negedge clock);
      {load_en, clear_exec, carry_force_one_op, carry_force_zero_op, priority_encode_op, error_clear} =
         {k == 6, k == 1, k == 2 || k == 7, k == 3 || k == 7, k == 4 || k == 8, k == 5 || k == 8};
      {clear_rung_in, carry_rung_in, enc_rung_in} = {3{ri}};
      {enc_src, enc_exp, clear_ptr, clear_size, load_addr, load_data, rd_addr} =
         {src, ex, p, sz, p[9:4], src[15:0], p[9:4]};
      chk = k != 6;
      rd = mem[p[9:4]]; // Read sees the word as it stood before this edge
      m = (ex inside {[1:8]}) ? (256'h1 << (1 << ex)) - 256'h1 : '0;
      est = 1'b0;
      case (k)
         1: begin
            cro = ri && sz != 0 && sz <= TABLE_WORDS_MAX && p[15:4] < sz;
            if (cro) mem[p[9:4]][p[3:0]] = 1'b0;
            else if (ri) ef = 1'b1;
         end
         2, 3, 7: begin
            kro = ri;
            if (ri) cf = k != 3;
         end
         4, 8: begin
            ero = ri && |(src & m);
            if (k == 8) ef = 1'b0;
            if (ri && !ero) ef = 1'b1;
            for (int i = 0; i < 256; i++) if (ero && src[i] && m[i]) ed = i[7:0];
            est = ero;
         end
         5: ef = 1'b0;
         6: mem[p[9:4]] = src[15:0];
         default: ;
      endcase
      if (chk) notes.push_back({cro, kro, cf, est, ero, ed, ef, rd});
   endtask : step
   // Main sequence, then a bounded watchdog
   initial begin
      void'($urandom(83958));
      // Quiet inputs through reset, so no strobe is seen before the first step
      {load_en, clear_exec, carry_force_one_op, carry_force_zero_op, priority_encode_op, error_clear} = 6'h00;
      {clear_rung_in, carry_rung_in, enc_rung_in, enc_src, enc_exp, clear_ptr, clear_size} = '0;
      {load_addr, load_data, rd_addr} = '0;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      for (int i = 0; i < 64; i++) step(6, 0, 256'($urandom), 0, 16'(i << 4), 0);
      foreach (ptr_list[j]) step(1, j != 7, 0, 0, 16'(ptr_list[j]), 7'(size_list[j]));
      step(0, 0, 0, 0, 56, 0);
      step(4, 1, 1, 1, 0, 0);
      step(4, 1, 256'h5, 3, 0, 0);
      step(4, 1, 256'h4, 1, 0, 0);
      step(4, 1, {1'b1, 255'h0}, 8, 0, 0);
      step(4, 1, '1, 9, 0, 0);
      step(4, 0, '1, 8, 0, 0);
      step(8, 1, 256'h80, 3, 0, 0);
      step(8, 1, 0, 3, 0, 0);
      for (int k = 2; k < 4; k++) for (int r = 0; r < 2; r++) step(k, r[0], 0, 0, 0, 0);
      step(7, 1, 0, 0, 0, 0);
      step(3, 1, 0, 0, 0, 0);
      step(7, 0, 0, 0, 0, 0);
      repeat (60) step($urandom_range(5, 0), 1'($urandom_range(1, 0)), {8{$urandom}} >> $urandom_range(255, 0),
         4'($urandom_range(15, 0)), 16'($urandom_range(1100, 0)), 7'($urandom_range(66, 0)));
      // Drop the strobes and stop watching, so the last step is not taken again
      @(negedge clock);
      chk = 1'b0;
      {load_en, clear_exec, carry_force_one_op, carry_force_zero_op, priority_encode_op, error_clear} = 6'h00;
      repeat (2) @(negedge clock);
      if (notes.size() != 0) failures++;
      end_sim();
   end
   initial begin
      #1ms;
      failures++;
      end_sim();
   end
endmodule : bit_table_carry_encode_ops_test
bind bit_table_carry_encode_ops bit_ops_monitor #(
   .WORDS(WORDS)
) i_mon (
   .clock(clock),
   .rst_n(rst_n),
   .clear_exec(clear_exec),
   .clear_rung_in(clear_rung_in),
   .clear_rung_out(clear_rung_out),
   .carry_force_one_op(carry_force_one_op),
   .carry_force_zero_op(carry_force_zero_op),
   .carry_rung_in(carry_rung_in),
   .carry_rung_out(carry_rung_out),
   .carry_flag(carry_flag),
   .priority_encode_op(priority_encode_op),
   .enc_rung_in(enc_rung_in),
   .enc_store(enc_store),
   .enc_rung_out(enc_rung_out),
   .error_flag(error_flag),
   .clear_ptr(clear_ptr),
   .clear_size(clear_size),
   .enc_src(enc_src),
   .enc_exp(enc_exp)
);
`default_nettype wire
